// ===== anar_pkg.sv
package anar_pkg;
   // Register indices on the management bus.
   localparam logic [4:0] ADDR_LOCAL_ADV = 5'h04;
   localparam logic [4:0] ADDR_PARTNER = 5'h05;
   localparam logic [4:0] ADDR_EXT_CTRL = 5'h10;

   // Field positions shared by both ability registers, and the extended control override bit.
   localparam int BIT_NEXT_PAGE = 15;
   localparam int BIT_RESERVED = 14;
   localparam int BIT_REMOTE_FAULT = 13;
   localparam int BIT_T4 = 9;
   localparam int BIT_TX_FD = 8;
   localparam int BIT_TX_HD = 7;
   localparam int BIT_10_FD = 6;
   localparam int BIT_10_HD = 5;
   localparam int BIT_OVERRIDE = 15;

   // Write masks: ordinary writable bits and override-only bits.
   localparam logic [15:0] MASK_RW = 16'h21e0;
   localparam logic [15:0] MASK_CW = 16'h1c1f;

   // Reset values, the remote fault mask and the selector codes.
   localparam logic [15:0] ADV_RESET_BASE = 16'h0001;
   localparam logic [15:0] ADV_RESET = 16'h01e1;
   localparam logic [15:0] MASK_RF = 16'h2000;
   localparam logic [15:0] PARTNER_RESET = 16'h0000;
   localparam logic [4:0] SEL_8023 = 5'h01;
   localparam logic [4:0] SEL_8029 = 5'h02;

   // Power-up sequencer steps after reset release.
   localparam logic [1:0] INIT_IDLE = 2'h0;
   localparam logic [1:0] INIT_LOAD = 2'h2;
   localparam logic [1:0] INIT_DONE = 2'h3;

   // One management access.
   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } anar_mgmt_req_t;

   // Strap pin group.
   typedef struct packed {
      logic hardware_software_strap_pin;
      logic autoneg_select_pin;
      logic duplex_select_pin;
      logic speed_select_pin;
   } anar_strap_t;
endpackage

// ===== anar_regs.sv
`timescale 1ns/1ps
// Operation
// - Advertisement next-page bit stays zero; writes ignored.
// - Advertisement bit 14 reserved, reads zero.
// - Bit 13 writable, resets zero, sets transmitted remote fault.
// - Power-up remote fault option also sets transmitted remote fault.
// - Bits 8 to 5 read/write, reset to one.
// - Bit 9 four-pair ability reads zero always.
// - Bits 12 to 10 reset zero, written only with override.
// - Software strap loads abilities from basic status capabilities.
// - Hardware strap with select pin sets one ability from pins.
// - Selector field resets to 00001.
// - Selector written only under command override.
// - Sixteen-bit advertisement sent to partner as code word.
// - Partner register read-only, resets zero, same layout.
// - Partner bit 13 shows received remote fault.
// - Partner selector 00001 for 802.3, 00010 for 802.9.
// - Partner bit 9 shows partner four-pair ability.
// - Override is self-clearing, enables next write to both classes.
module anar_regs (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Management access, same clock
   input wire logic i_mgmt_en,
   input wire anar_pkg::anar_mgmt_req_t i_mgmt_req,
   output logic [15:0] o_rdata,
   // Strap pins, asynchronous
   input wire anar_pkg::anar_strap_t i_strap,
   // Basic status capability bits 14:11 and power-up fault option
   input wire logic [3:0] i_status_caps,
   input wire logic i_powerup_fault_opt,
   // Received code word from the arbitration engine
   input wire logic i_rx_word_valid,
   input wire logic [15:0] i_rx_word,
   // Code word to transmit and override flag
   output logic [15:0] o_tx_word,
   output logic o_override
);
   logic [15:0] adv_q, adv_d, partner_q;
   logic override_q, override_d;
   logic [1:0] init_q;
   anar_pkg::anar_strap_t strap_s1_q, strap_s2_q;

   wire wr_en = i_mgmt_en && i_mgmt_req.wr;
   wire wr_adv = wr_en && (i_mgmt_req.addr == anar_pkg::ADDR_LOCAL_ADV);
   wire wr_ext = wr_en && (i_mgmt_req.addr == anar_pkg::ADDR_EXT_CTRL);
   wire [15:0] wmask = override_q ?
      (anar_pkg::MASK_RW | anar_pkg::MASK_CW) : anar_pkg::MASK_RW;

   // Merge a write into a register under a per-bit enable mask.
   function automatic logic [15:0] anar_merge(input logic [15:0] old_val,
      input logic [15:0] new_val, input logic [15:0] mask);
      anar_merge = (old_val & ~mask) | (new_val & mask);
   endfunction

   // Ability bits chosen by the strap; taken once after reset release,
   // because the pins may still be settling while reset is asserted.
   // The load waits until the second synchroniser stage holds the pins,
   // so the value taken is never the stage's own reset value.
   logic [3:0] strap_abil;
   always_comb begin
      strap_abil = 4'h0;
      if (!strap_s2_q.hardware_software_strap_pin) begin
         strap_abil = i_status_caps;
      end else if (strap_s2_q.autoneg_select_pin) begin
         strap_abil[{strap_s2_q.speed_select_pin,
                     strap_s2_q.duplex_select_pin}] = 1'b1;
      end else begin
         strap_abil = 4'hf;
      end
   end

   always_comb begin
      adv_d = adv_q;
      if (init_q == anar_pkg::INIT_LOAD) begin
         adv_d[anar_pkg::BIT_TX_FD:anar_pkg::BIT_10_HD] = strap_abil;
      end else if (wr_adv) begin
         // Override gates selector and bits 12 to 10 writes.
         adv_d = anar_merge(adv_q, i_mgmt_req.wdata, wmask);
      end
      adv_d[anar_pkg::BIT_NEXT_PAGE] = 1'b0;
      adv_d[anar_pkg::BIT_RESERVED] = 1'b0;
      adv_d[anar_pkg::BIT_T4] = 1'b0;
   end

   // Override set by write, cleared by next register write.
   always_comb begin
      override_d = override_q;
      if (wr_ext) begin
         override_d = i_mgmt_req.wdata[anar_pkg::BIT_OVERRIDE];
      end else if (wr_en) begin
         override_d = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         strap_s1_q <= '0;
         strap_s2_q <= '0;
         init_q <= anar_pkg::INIT_IDLE;
      end else begin
         strap_s1_q <= i_strap;
         strap_s2_q <= strap_s1_q;
         if (init_q != anar_pkg::INIT_DONE) begin
            init_q <= init_q + 2'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         adv_q <= anar_pkg::ADV_RESET;
         override_q <= 1'b0;
      end else begin
         adv_q <= adv_d;
         override_q <= override_d;
      end
   end

   // Partner register latch on accepted word.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         partner_q <= anar_pkg::PARTNER_RESET;
      end else if (i_rx_word_valid) begin
         partner_q <= i_rx_word;
      end
   end

   wire [15:0] partner_view = {partner_q[15], 1'b0, partner_q[13:0]};

   always_comb begin
      case (i_mgmt_req.addr)
         anar_pkg::ADDR_LOCAL_ADV: o_rdata = adv_q;
         anar_pkg::ADDR_PARTNER: o_rdata = partner_view;
         anar_pkg::ADDR_EXT_CTRL: o_rdata = {override_q, 15'h0000};
         default: o_rdata = 16'h0000;
      endcase
   end

   always_comb begin
      o_tx_word = adv_q;
      o_tx_word[anar_pkg::BIT_REMOTE_FAULT] =
         adv_q[anar_pkg::BIT_REMOTE_FAULT] | i_powerup_fault_opt;
   end
   assign o_override = override_q;

   // Checks on the advertisement register. Writes are only judged once
   // the power-up load is over, because the load owns bits 8 to 5 until
   // then and a write made in the load step itself is deliberately dropped.

   // The next-page bit must never reach the register.
   a_np_zero: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      !adv_q[anar_pkg::BIT_NEXT_PAGE])
      else $error("adv next page set");

   // The reserved bit must read back as zero.
   a_rsv_zero: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      !adv_q[anar_pkg::BIT_RESERVED])
      else $error("adv reserved bit set");

   // Four-pair ability is unsupported and stays clear.
   a_t4_zero: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      !adv_q[anar_pkg::BIT_T4])
      else $error("adv t4 set");

   // The transmitted fault bit is the register bit or the option.
   a_rf_tx: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (adv_q[anar_pkg::BIT_REMOTE_FAULT] || i_powerup_fault_opt) ==
      o_tx_word[anar_pkg::BIT_REMOTE_FAULT])
      else $error("tx fault wrong");

   // Every other transmitted bit is the register bit unchanged.
   a_tx_copy: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (o_tx_word & ~anar_pkg::MASK_RF) == (adv_q & ~anar_pkg::MASK_RF))
      else $error("tx word differs");

   // The strap load takes the decoded abilities into bits 8 to 5.
   a_strap_load: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (init_q == anar_pkg::INIT_LOAD) |=>
      adv_q[anar_pkg::BIT_TX_FD:anar_pkg::BIT_10_HD] == $past(strap_abil))
      else $error("strap load wrong");

   // Ordinary bits follow every write once the load is over.
   a_rw_write: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (wr_adv && init_q == anar_pkg::INIT_DONE) |=>
      (adv_q & anar_pkg::MASK_RW) ==
      ($past(i_mgmt_req.wdata) & anar_pkg::MASK_RW))
      else $error("rw bits not written");

   // Override-only bits ignore a write made without override.
   a_cw_guard: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (wr_adv && !override_q && init_q == anar_pkg::INIT_DONE) |=>
      (adv_q & anar_pkg::MASK_CW) == ($past(adv_q) & anar_pkg::MASK_CW))
      else $error("cw bits changed");

   // The selector keeps its value without override.
   a_sel_guard: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (wr_adv && !override_q && init_q == anar_pkg::INIT_DONE) |=>
      adv_q[4:0] == $past(adv_q[4:0]))
      else $error("selector changed");

   // With override the selector takes the written value.
   a_sel_write: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (wr_adv && override_q && init_q == anar_pkg::INIT_DONE) |=>
      adv_q[4:0] == $past(i_mgmt_req.wdata[4:0]))
      else $error("selector not written");

   // Without a write the register holds, so a stale strobe cannot apply
   // an old value again.
   a_adv_hold: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (!wr_adv && init_q == anar_pkg::INIT_DONE) |=> $stable(adv_q))
      else $error("adv changed");

   // Checks on the override flag.

   // A write to the extended control register sets or clears it.
   a_ovr_set: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      wr_ext |=> override_q == $past(i_mgmt_req.wdata[anar_pkg::BIT_OVERRIDE]))
      else $error("override not taken");

   // Any other write uses the override once and clears it.
   a_ovr_clear: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (override_q && wr_en && !wr_ext) |=> !override_q)
      else $error("override stuck");

   // Reads alone never touch the flag.
   a_ovr_hold: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      !wr_en |=> $stable(override_q))
      else $error("override moved");

   // Checks on the partner register and the read path.

   // An accepted word is taken whole at the next edge.
   a_partner_upd: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      i_rx_word_valid |=> partner_q == $past(i_rx_word))
      else $error("partner not updated");

   // Without a word the partner register holds.
   a_partner_hold: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      !i_rx_word_valid |=> $stable(partner_q))
      else $error("partner changed");

   // Partner reads hide bit 14 but show fault and four-pair as received.
   a_rd_partner: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (i_mgmt_req.addr == anar_pkg::ADDR_PARTNER) |->
      (!o_rdata[anar_pkg::BIT_RESERVED] &&
      o_rdata[anar_pkg::BIT_REMOTE_FAULT] ==
      partner_q[anar_pkg::BIT_REMOTE_FAULT] &&
      o_rdata[anar_pkg::BIT_T4] == partner_q[anar_pkg::BIT_T4]))
      else $error("partner read wrong");

   // Advertisement reads return the register as it stands.
   a_rd_adv: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (i_mgmt_req.addr == anar_pkg::ADDR_LOCAL_ADV) |-> o_rdata == adv_q)
      else $error("adv read wrong");

   // Extended control reads show only the override flag.
   a_rd_ext: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (i_mgmt_req.addr == anar_pkg::ADDR_EXT_CTRL) |->
      o_rdata == {override_q, 15'h0000})
      else $error("ext read wrong");

   // Main scenarios that the bench is expected to reach.
   c_override_wr: cover property (@(posedge i_clk)
      override_q && wr_adv);
   c_rx_word: cover property (@(posedge i_clk)
      i_rx_word_valid);
   c_fault_opt: cover property (@(posedge i_clk)
      i_powerup_fault_opt);
   c_strap_hw: cover property (@(posedge i_clk)
      init_q == anar_pkg::INIT_LOAD &&
      strap_s2_q.hardware_software_strap_pin);
endmodule

// ===== anar_link_model.sv
`timescale 1ns/1ps
module anar_link_model (
   // Clock and request from the bench
   input wire logic i_clk,
   input wire logic i_send,
   input wire logic [15:0] i_word,
   // Accepted code word towards the block
   output logic o_valid,
   output logic [15:0] o_word
);
   logic [15:0] idle_q = 16'h5a5a;
   // The word lines are not held between words, so stale data is caught.
   always_ff @(posedge i_clk) begin
      idle_q <= ~idle_q;
   end
   assign o_valid = i_send;
   assign o_word = i_send ? i_word : idle_q;
endmodule

// ===== test_autoneg_ability_registers.sv
`timescale 1ns/1ps
module test_autoneg_ability_registers;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic en = 1'b0;
   logic send = 1'b0;
   logic fopt = 1'b0;
   logic ovr;
   logic valid;
   logic [3:0] caps = 4'ha;
   logic [15:0] sword = 16'h0000;
   logic [15:0] word;
   logic [15:0] rdata;
   logic [15:0] tx;
   anar_pkg::anar_mgmt_req_t req = '{1'b0, 5'h00, 16'h0000};
   anar_pkg::anar_strap_t strap = '{1'b0, 1'b0, 1'b0, 1'b0};
   int num_errors = 0;
   int samples_checked = 0;

   always #25 clk = ~clk;

   anar_regs dut_u (.i_clk(clk), .i_resetn(resetn), .i_mgmt_en(en),
      .i_mgmt_req(req), .o_rdata(rdata), .i_strap(strap),
      .i_status_caps(caps), .i_powerup_fault_opt(fopt),
      .i_rx_word_valid(valid), .i_rx_word(word), .o_tx_word(tx),
      .o_override(ovr));
   anar_link_model link_u (.i_clk(clk), .i_send(send), .i_word(sword),
      .o_valid(valid), .o_word(word));

   task print_verdict;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input string name, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", name, e, g);
         num_errors++;
      end
   endtask

   task rd(input logic [4:0] a, input logic [15:0] e);
      @(negedge clk);
      req = '{1'b0, a, 16'h0000};
      #1 chk("rdata", e, rdata);
   endtask

   task wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      en = 1'b1;
      req = '{1'b1, a, d};
      @(negedge clk);
      en = 1'b0;
      req.wr = 1'b0;
   endtask

   task rx(input logic [15:0] w);
      @(negedge clk);
      send = 1'b1;
      sword = w;
      @(negedge clk);
      send = 1'b0;
   endtask

   // Straps settle before reset, so the synchroniser sees them stable.
   task rst;
      @(negedge clk);
      resetn = 1'b0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   initial begin
      rst;
      rd(5'h04, 16'h0141);
      rd(5'h05, 16'h0000);
      rd(5'h07, 16'h0000);
      wr(5'h04, 16'hffff);
      rd(5'h04, 16'h21e1);
      chk("tx", 16'h21e1, tx);
      wr(5'h04, 16'h0000);
      chk("tx", 16'h0001, tx);
      fopt = 1'b1;
      #1 chk("tx", 16'h2001, tx);
      fopt = 1'b0;
      wr(5'h10, 16'h8000);
      chk("override", 16'h0001, {15'h0000, ovr});
      wr(5'h04, 16'hffff);
      chk("override", 16'h0000, {15'h0000, ovr});
      rd(5'h04, 16'h3dff);
      wr(5'h04, 16'h0000);
      rd(5'h04, 16'h1c1f);
      wr(5'h10, 16'h8000);
      wr(5'h04, 16'h01e1);
      rd(5'h04, 16'h01e1);
      rx(16'he3e2);
      rd(5'h05, 16'ha3e2);
      rx(16'h01e1);
      wr(5'h05, 16'hffff);
      repeat (3) @(negedge clk);
      rd(5'h05, 16'h01e1);
      strap = '{1'b1, 1'b1, 1'b1, 1'b0};
      rst;
      rd(5'h04, 16'h0041);
      rd(5'h05, 16'h0000);
      print_verdict;
   end

   initial begin
      #200000;
      num_errors++;
      print_verdict;
   end
endmodule
